/* shared/csarp_pkg.sv */
// Shared constants and types for the core status register and data memory partition.
package csarp_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Data memory geometry.
  localparam int CSARP_BANK_COUNT = 32;
  localparam int CSARP_BANK_BYTES = 128;
  localparam int CSARP_GEN_PER_BANK = 80;
  localparam int CSARP_COMMON_BYTES = 16;
  localparam int CSARP_BANK_W = 5;
  localparam int CSARP_OFS_W = 7;
  localparam int CSARP_IDX_W = 12;
  localparam int CSARP_COMMON_W = 4;

  ////////////////////////////////////////////////////////////////////////////////
  // Offsets inside every bank.
  localparam logic [6:0] CSARP_OFS_STATUS = 7'h03;
  localparam logic [6:0] CSARP_OFS_BANK_SEL = 7'h08;
  localparam logic [6:0] CSARP_OFS_GEN_LO = 7'h20;
  localparam logic [6:0] CSARP_OFS_GEN_HI = 7'h6F;
  localparam logic [6:0] CSARP_OFS_COMMON_LO = 7'h70;

  ////////////////////////////////////////////////////////////////////////////////
  // Indirect address regions.
  localparam logic [15:0] CSARP_BANKED_TOP = 16'h1000;
  localparam logic [15:0] CSARP_LINEAR_BASE = 16'h2000;

  ////////////////////////////////////////////////////////////////////////////////
  // Status register layout and reset values.
  localparam int CSARP_BIT_WDOG = 4;
  localparam int CSARP_BIT_SLEEP = 3;
  localparam int CSARP_BIT_NULL = 2;
  localparam int CSARP_BIT_NIBBLE = 1;
  localparam int CSARP_BIT_MSB = 0;
  localparam logic CSARP_RST_CAUSE = 1'b1;
  localparam logic CSARP_RST_ARITH = 1'b0;
  localparam logic [2:0] CSARP_UNUSED_BITS = 3'h0;
  localparam int CSARP_NIBBLE_W = 4;
  localparam logic [7:0] CSARP_BYTE_ZERO = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Execute operations, one-hot.
  typedef enum logic [9:0] {
    CSARP_OP_ADD = 10'h001,
    CSARP_OP_SUB = 10'h002,
    CSARP_OP_AND = 10'h004,
    CSARP_OP_OR = 10'h008,
    CSARP_OP_XOR = 10'h010,
    CSARP_OP_ROTR = 10'h020,
    CSARP_OP_ROTL = 10'h040,
    CSARP_OP_CLEAR = 10'h080,
    CSARP_OP_SWAP = 10'h100,
    CSARP_OP_MOVE = 10'h200
  } csarp_op_type;

  // Decoded target of a data memory address, one-hot.
  typedef enum logic [4:0] {
    CSARP_TGT_NONE = 5'h01,
    CSARP_TGT_STATUS = 5'h02,
    CSARP_TGT_BANK = 5'h04,
    CSARP_TGT_GEN = 5'h08,
    CSARP_TGT_COMMON = 5'h10
  } csarp_target_type;

  typedef struct packed {
    csarp_target_type target;
    logic [CSARP_IDX_W-1:0] idx;
  } csarp_dec_type;

endpackage

/* rtl/csarp_alu.sv */
// Arithmetic and logic unit producing the result byte and the three arithmetic flags.
module csarp_alu
  import csarp_pkg::*;
(
  // Operation and operands.
  input wire csarp_op_type op,
  input wire logic [7:0] operand_a,
  input wire logic [7:0] operand_b,
  input wire logic carry_in,
  // Result and flags.
  output logic [7:0] result,
  output logic null_result_flag,
  output logic nibble_overflow_bit,
  output logic msb_overflow_bit,
  output logic null_update,
  output logic nibble_update,
  output logic msb_update
);

  logic [8:0] sum;
  logic [4:0] low_sum;

  always_comb begin
    sum = {1'b0, operand_b} + {1'b0, operand_a};
    low_sum = {1'b0, operand_b[3:0]} + {1'b0, operand_a[3:0]};
    result = CSARP_BYTE_ZERO;
    msb_overflow_bit = 1'b0;
    null_update = 1'b0;
    nibble_update = 1'b0;
    msb_update = 1'b0;
    unique case (op)
      CSARP_OP_ADD: begin
        result = sum[7:0];
        null_update = 1'b1;
        nibble_update = 1'b1;
        msb_update = 1'b1;
        msb_overflow_bit = sum[8];
      end
      CSARP_OP_SUB: begin
        sum = {1'b0, operand_b} + {1'b0, ~operand_a} + 9'h001;
        low_sum = {1'b0, operand_b[3:0]} + {1'b0, ~operand_a[3:0]} + 5'h01;
        result = sum[7:0];
        null_update = 1'b1;
        nibble_update = 1'b1;
        msb_update = 1'b1;
        msb_overflow_bit = sum[8];
      end
      CSARP_OP_AND: begin
        result = operand_a & operand_b;
        null_update = 1'b1;
      end
      CSARP_OP_OR: begin
        result = operand_a | operand_b;
        null_update = 1'b1;
      end
      CSARP_OP_XOR: begin
        result = operand_a ^ operand_b;
        null_update = 1'b1;
      end
      CSARP_OP_ROTR: begin
        result = {carry_in, operand_b[7:1]};
        msb_update = 1'b1;
        msb_overflow_bit = operand_b[0];
      end
      CSARP_OP_ROTL: begin
        result = {operand_b[6:0], carry_in};
        msb_update = 1'b1;
        msb_overflow_bit = operand_b[7];
      end
      CSARP_OP_CLEAR: begin
        result = CSARP_BYTE_ZERO;
        null_update = 1'b1;
      end
      CSARP_OP_SWAP: begin
        result = {operand_b[3:0], operand_b[7:4]};
      end
      CSARP_OP_MOVE: begin
        result = operand_a;
      end
      default: begin
        result = CSARP_BYTE_ZERO;
      end
    endcase
    null_result_flag = (result == CSARP_BYTE_ZERO);
    nibble_overflow_bit = low_sum[CSARP_NIBBLE_W];
  end

endmodule

/* rtl/csarp_status_ram.sv */
// Processor status register, bank select and banked data memory with common and linear RAM.
//
// Summary of operation
// - Status bits seven to five read zero and ignore writes.
// - Watchdog expired flag sets at power-up, and on watchdog kick or halt in a cycle without a timeout.
// - Watchdog expired flag clears when the watchdog times out.
// - Sleep entered flag sets at power-up and on watchdog kick.
// - Sleep entered flag clears when the halt instruction executes without a watchdog kick.
// - Null result flag follows whether the arithmetic or logic result is zero.
// - Add and subtract load the carry out of bit three.
// - Add and subtract load the carry out of bit seven.
// - Subtract adds the twos complement; carries mean no borrow.
// - Rotates load the bit shifted out into the msb overflow bit.
// - Cause flags read-only, one at power-on; arithmetic flags writable, zero.
// - Clearing the status register zeroes upper bits and sets null flag only.
// - Each bank holds at most eighty bytes of general RAM.
// - General RAM is reachable linearly through the indirect pointer.
// - Sixteen common bytes map identically in every bank.
// - Thirty-two banks of 128 bytes; bank select picks; holes read zero.
// - Flag-affecting instructions cannot write the arithmetic flags by data.
module csarp_status_ram
  import csarp_pkg::*;
#(
  parameter int GEN_BANKS = CSARP_BANK_COUNT
)
(
  // Clock and synchronous power-on reset.
  input wire logic clock,
  input wire logic reset_n,
  // Reset-cause events, one-cycle pulses.
  input wire logic watchdog_kick_instruction,
  input wire logic halt_instruction,
  input wire logic watchdog_timeout,
  // Instruction execute and write-back.
  input wire logic exec_valid,
  input wire csarp_op_type exec_op,
  input wire logic [7:0] exec_operand_a,
  input wire logic [7:0] exec_operand_b,
  input wire logic exec_to_file,
  input wire logic exec_indirect,
  input wire logic [15:0] exec_addr,
  output logic [7:0] exec_result,
  // File read port.
  input wire logic read_en,
  input wire logic read_indirect,
  input wire logic [15:0] read_addr,
  output logic [7:0] read_data,
  // Register views for the core.
  output logic [7:0] processor_status,
  output logic [4:0] bank_select_register
);

  localparam int GEN_DEPTH = GEN_BANKS * CSARP_GEN_PER_BANK;

  ////////////////////////////////////////////////////////////////////////////////
  // Address decode shared by the read and write ports.

  function automatic csarp_dec_type decode_addr(
    input logic ind,
    input logic [15:0] addr,
    input logic [4:0] bank
  );
    csarp_dec_type dec;
    logic [4:0] b;
    logic [6:0] ofs;
    logic [15:0] lin;
    dec.target = CSARP_TGT_NONE;
    dec.idx = '0;
    b = bank;
    ofs = addr[CSARP_OFS_W-1:0];
    lin = addr - CSARP_LINEAR_BASE;
    if (ind && addr >= CSARP_LINEAR_BASE) begin
      if (lin < 16'(GEN_DEPTH)) begin
        dec.target = CSARP_TGT_GEN;
        dec.idx = lin[CSARP_IDX_W-1:0];
      end
    end else if (!ind || addr < CSARP_BANKED_TOP) begin
      if (ind) begin
        b = addr[CSARP_OFS_W+CSARP_BANK_W-1:CSARP_OFS_W];
      end
      if (ofs == CSARP_OFS_STATUS) begin
        dec.target = CSARP_TGT_STATUS;
      end else if (ofs == CSARP_OFS_BANK_SEL) begin
        dec.target = CSARP_TGT_BANK;
      end else if (ofs >= CSARP_OFS_COMMON_LO) begin
        dec.target = CSARP_TGT_COMMON;
        dec.idx = CSARP_IDX_W'(ofs - CSARP_OFS_COMMON_LO);
      end else if (ofs >= CSARP_OFS_GEN_LO && ofs <= CSARP_OFS_GEN_HI &&
                   {1'b0, b} < 6'(GEN_BANKS)) begin
        dec.target = CSARP_TGT_GEN;
        dec.idx = CSARP_IDX_W'(b) * CSARP_IDX_W'(CSARP_GEN_PER_BANK) +
                  CSARP_IDX_W'(ofs - CSARP_OFS_GEN_LO);
      end
    end
    return dec;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Arithmetic unit.

  logic [7:0] alu_result;
  logic alu_null;
  logic alu_nibble;
  logic alu_msb;
  logic upd_null;
  logic upd_nibble;
  logic upd_msb;
  logic msb_overflow_bit_q;

  csarp_alu u_alu (
    .op(exec_op),
    .operand_a(exec_operand_a),
    .operand_b(exec_operand_b),
    .carry_in(msb_overflow_bit_q),
    .result(alu_result),
    .null_result_flag(alu_null),
    .nibble_overflow_bit(alu_nibble),
    .msb_overflow_bit(alu_msb),
    .null_update(upd_null),
    .nibble_update(upd_nibble),
    .msb_update(upd_msb)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Write-back decode.

  csarp_dec_type wr_dec;
  csarp_dec_type rd_dec;
  logic wr_en;
  logic flags_touched;
  logic status_data_wr;

  always_comb begin
    wr_dec = decode_addr(exec_indirect, exec_addr, bank_select_register);
    rd_dec = decode_addr(read_indirect, read_addr, bank_select_register);
    wr_en = exec_valid && exec_to_file;
    flags_touched = upd_null || upd_nibble || upd_msb;
    status_data_wr = wr_en && (wr_dec.target == CSARP_TGT_STATUS) && !flags_touched;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Status register.

  logic watchdog_expired_flag_q;
  logic watchdog_expired_flag_d;
  logic sleep_entered_flag_q;
  logic sleep_entered_flag_d;
  logic null_result_flag_q;
  logic null_result_flag_d;
  logic nibble_overflow_bit_q;
  logic nibble_overflow_bit_d;
  logic msb_overflow_bit_d;

  always_comb begin
    watchdog_expired_flag_d = watchdog_expired_flag_q;
    sleep_entered_flag_d = sleep_entered_flag_q;
    null_result_flag_d = null_result_flag_q;
    nibble_overflow_bit_d = nibble_overflow_bit_q;
    msb_overflow_bit_d = msb_overflow_bit_q;
    if (status_data_wr) begin
      null_result_flag_d = alu_result[CSARP_BIT_NULL];
      nibble_overflow_bit_d = alu_result[CSARP_BIT_NIBBLE];
      msb_overflow_bit_d = alu_result[CSARP_BIT_MSB];
    end
    if (exec_valid) begin
      if (upd_null) begin
        null_result_flag_d = alu_null;
      end
      if (upd_nibble) begin
        nibble_overflow_bit_d = alu_nibble;
      end
      if (upd_msb) begin
        msb_overflow_bit_d = alu_msb;
      end
    end
    if (watchdog_kick_instruction || halt_instruction) begin
      watchdog_expired_flag_d = 1'b1;
    end
    if (watchdog_kick_instruction) begin
      sleep_entered_flag_d = 1'b1;
    end
    if (halt_instruction && !watchdog_kick_instruction) begin
      sleep_entered_flag_d = 1'b0;
    end
    if (watchdog_timeout) begin
      watchdog_expired_flag_d = 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      watchdog_expired_flag_q <= CSARP_RST_CAUSE;
      sleep_entered_flag_q <= CSARP_RST_CAUSE;
      null_result_flag_q <= CSARP_RST_ARITH;
      nibble_overflow_bit_q <= CSARP_RST_ARITH;
      msb_overflow_bit_q <= CSARP_RST_ARITH;
    end else begin
      watchdog_expired_flag_q <= watchdog_expired_flag_d;
      sleep_entered_flag_q <= sleep_entered_flag_d;
      null_result_flag_q <= null_result_flag_d;
      nibble_overflow_bit_q <= nibble_overflow_bit_d;
      msb_overflow_bit_q <= msb_overflow_bit_d;
    end
  end

  assign processor_status = {CSARP_UNUSED_BITS, watchdog_expired_flag_q, sleep_entered_flag_q,
                             null_result_flag_q, nibble_overflow_bit_q, msb_overflow_bit_q};

  ////////////////////////////////////////////////////////////////////////////////
  // Bank select register.

  logic [4:0] bank_select_q;
  logic [4:0] bank_select_d;

  always_comb begin
    bank_select_d = bank_select_q;
    if (wr_en && wr_dec.target == CSARP_TGT_BANK) begin
      bank_select_d = alu_result[CSARP_BANK_W-1:0];
    end
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bank_select_q <= '0;
    end else begin
      bank_select_q <= bank_select_d;
    end
  end

  assign bank_select_register = bank_select_q;

  ////////////////////////////////////////////////////////////////////////////////
  // General and common RAM.

  logic [7:0] gen_mem [GEN_DEPTH];
  logic [7:0] common_mem [CSARP_COMMON_BYTES];
  logic gen_we;
  logic common_we;

  always_comb begin
    gen_we = wr_en && wr_dec.target == CSARP_TGT_GEN;
    common_we = wr_en && wr_dec.target == CSARP_TGT_COMMON;
  end

  always_ff @(posedge clock) begin
    if (gen_we) begin
      gen_mem[wr_dec.idx] <= alu_result;
    end
    if (common_we) begin
      common_mem[wr_dec.idx[CSARP_COMMON_W-1:0]] <= alu_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read port and result register.

  logic [7:0] read_data_q;
  logic [7:0] read_data_d;
  logic [7:0] exec_result_q;
  logic [7:0] exec_result_d;

  always_comb begin
    read_data_d = read_data_q;
    if (read_en) begin
      unique case (rd_dec.target)
        CSARP_TGT_STATUS: read_data_d = processor_status;
        CSARP_TGT_BANK: read_data_d = {3'h0, bank_select_q};
        CSARP_TGT_GEN: read_data_d = gen_mem[rd_dec.idx];
        CSARP_TGT_COMMON: read_data_d = common_mem[rd_dec.idx[CSARP_COMMON_W-1:0]];
        CSARP_TGT_NONE: read_data_d = CSARP_BYTE_ZERO;
        default: read_data_d = CSARP_BYTE_ZERO;
      endcase
    end
    exec_result_d = exec_valid ? alu_result : exec_result_q;
  end

  always_ff @(posedge clock) begin
    if (!reset_n) begin
      read_data_q <= CSARP_BYTE_ZERO;
      exec_result_q <= CSARP_BYTE_ZERO;
    end else begin
      read_data_q <= read_data_d;
      exec_result_q <= exec_result_d;
    end
  end

  assign read_data = read_data_q;
  assign exec_result = exec_result_q;

endmodule

/* testbench/csarp_status_ram_assertions.sv */
// Checker for the status register and data memory block.
module csarp_status_ram_assertions
  import csarp_pkg::*;
#(
  parameter int GEN_BANKS = CSARP_BANK_COUNT
)
(
  // Clock and reset.
  input wire logic clock,
  input wire logic reset_n,
  // Events.
  input wire logic watchdog_kick_instruction,
  input wire logic halt_instruction,
  input wire logic watchdog_timeout,
  // Execute.
  input wire logic exec_valid,
  input wire csarp_op_type exec_op,
  input wire logic [7:0] exec_operand_a,
  input wire logic [7:0] exec_operand_b,
  input wire logic exec_to_file,
  input wire logic exec_indirect,
  input wire logic [15:0] exec_addr,
  input wire logic [7:0] exec_result,
  // Read and status.
  input wire logic read_en,
  input wire logic read_indirect,
  input wire logic [15:0] read_addr,
  input wire logic [7:0] read_data,
  input wire logic [7:0] processor_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [8:0] add_s;
  logic [8:0] sub_s;
  logic [4:0] add_n;
  logic [4:0] sub_n;
  logic [9:0] add_v;
  logic [9:0] sub_v;
  logic [1:0] low_flags;
  logic rot_out;
  logic st_wr;
  logic no_event;

  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  ////////////////////////////////////////
  // Reference sums from the inputs.
  assign add_s = {1'b0, exec_operand_a} + {1'b0, exec_operand_b};
  assign sub_s = {1'b0, exec_operand_b} + {1'b0, ~exec_operand_a} + 9'h001;
  assign add_n = {1'b0, exec_operand_a[3:0]} + {1'b0, exec_operand_b[3:0]};
  assign sub_n = {1'b0, exec_operand_b[3:0]} + {1'b0, ~exec_operand_a[3:0]} + 5'h01;
  assign add_v = {add_s[7:0], add_n[4], add_s[8]};
  assign sub_v = {sub_s[7:0], sub_n[4], sub_s[8]};
  assign low_flags = processor_status[1:0];
  assign rot_out = (exec_op == CSARP_OP_ROTL) ? exec_operand_b[7] : exec_operand_b[0];
  assign st_wr = exec_valid && exec_to_file && !exec_indirect
    && exec_addr[6:0] == CSARP_OFS_STATUS;
  assign no_event = !(watchdog_kick_instruction || halt_instruction || watchdog_timeout);

  ////////////////////////////////////////
  // upper bits zero.
  a_upper_bits_zero: assert property (processor_status[7:5] == 3'h0)
    else $error("status upper bits set");
  a_kick_sets_cause: assert property (watchdog_kick_instruction && !watchdog_timeout
    |=> processor_status[4:3] == 2'h3) else $error("kick did not set cause flags");
  a_timeout_clears: assert property (watchdog_timeout |=> !processor_status[4])
    else $error("timeout did not clear flag");
  a_halt_clears_sleep: assert property (halt_instruction && no_event == 1'b0
    && !watchdog_kick_instruction && !watchdog_timeout |=> processor_status[4:3] == 2'h2)
    else $error("halt did not update cause flags");
  a_cause_held: assert property (no_event |=> $stable(processor_status[4:3]))
    else $error("cause flags moved without event");
  a_zero_follows: assert property (exec_valid && exec_op inside {CSARP_OP_ADD,
    CSARP_OP_SUB, CSARP_OP_AND, CSARP_OP_OR, CSARP_OP_XOR}
    |=> processor_status[2] == (exec_result == 8'h00)) else $error("zero flag wrong");
  a_add_carries: assert property (exec_valid && exec_op == CSARP_OP_ADD
    |=> {exec_result, low_flags} == $past(add_v)) else $error("add result or carry wrong");
  a_sub_borrows: assert property (exec_valid && exec_op == CSARP_OP_SUB
    |=> {exec_result, low_flags} == $past(sub_v)) else $error("sub result or borrow wrong");
  a_rotate_carry: assert property (exec_valid && exec_op inside {CSARP_OP_ROTR,
    CSARP_OP_ROTL} |=> processor_status[0] == $past(rot_out)) else $error("rotate carry wrong");
  a_clear_status: assert property (st_wr && exec_op == CSARP_OP_CLEAR
    |=> processor_status[2] && low_flags == $past(low_flags)) else $error("clear status wrong");
  a_flag_write_block: assert property (st_wr && exec_op inside {CSARP_OP_AND,
    CSARP_OP_OR, CSARP_OP_XOR} |=> low_flags == $past(low_flags)) else $error("flags written");
  a_hole_reads_zero: assert property (read_en && !read_indirect
    && read_addr[6:0] == 7'h0C |=> read_data == 8'h00) else $error("hole read not zero");

  c_add_seen: cover property (exec_valid && exec_op == CSARP_OP_ADD);
  c_status_write: cover property (st_wr);
  c_timeout_seen: cover property (watchdog_timeout);
endmodule

bind csarp_status_ram csarp_status_ram_assertions #(.GEN_BANKS(GEN_BANKS))
  csarp_status_ram_assertions_inst (.clock, .reset_n, .watchdog_kick_instruction,
  .halt_instruction, .watchdog_timeout, .exec_valid, .exec_op, .exec_operand_a,
  .exec_operand_b, .exec_to_file, .exec_indirect, .exec_addr, .exec_result, .read_en,
  .read_indirect, .read_addr, .read_data, .processor_status);

/* testbench/csarp_core_model.sv */
// Core model that issues instructions, events and reads to the status block.
module csarp_core_model
  import csarp_pkg::*;
(
  // Clock.
  input wire logic clock,
  // Events.
  output logic watchdog_kick_instruction,
  output logic halt_instruction,
  output logic watchdog_timeout,
  // Execute.
  output logic exec_valid,
  output csarp_op_type exec_op,
  output logic [7:0] exec_operand_a,
  output logic [7:0] exec_operand_b,
  output logic exec_to_file,
  output logic exec_indirect,
  output logic [15:0] exec_addr,
  // Read.
  output logic read_en,
  output logic read_indirect,
  output logic [15:0] read_addr
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    {watchdog_kick_instruction, halt_instruction, watchdog_timeout} = 3'h0;
    {exec_valid, exec_to_file, exec_indirect, read_en, read_indirect} = 5'h00;
    {exec_operand_a, exec_operand_b, exec_addr, read_addr} = 48'h0000_0000_0000;
    exec_op = CSARP_OP_MOVE;
  end

  // Drops every request; operand A and the read address show their inverse.
  task automatic idle();
    @(negedge clock);
    {watchdog_kick_instruction, halt_instruction, watchdog_timeout} = 3'h0;
    {exec_valid, read_en} = 2'h0;
    exec_operand_a = ~exec_operand_a;
    read_addr = ~read_addr;
  endtask

  task automatic exec(csarp_op_type op, logic [7:0] a, logic [7:0] b, logic tf, logic ind,
    logic [15:0] addr);
    @(negedge clock);
    {watchdog_kick_instruction, halt_instruction, watchdog_timeout} = 3'h0;
    {exec_valid, read_en} = 2'h2;
    exec_op = op;
    {exec_operand_a, exec_operand_b} = {a, b};
    {exec_to_file, exec_indirect, exec_addr} = {tf, ind, addr};
  endtask

  task automatic pulse(logic k, logic h, logic t);
    @(negedge clock);
    {exec_valid, read_en} = 2'h0;
    {watchdog_kick_instruction, halt_instruction, watchdog_timeout} = {k, h, t};
  endtask

  task automatic rd(logic ind, logic [15:0] addr);
    @(negedge clock);
    {watchdog_kick_instruction, halt_instruction, watchdog_timeout} = 3'h0;
    {exec_valid, read_en, read_indirect, read_addr} = {2'h1, ind, addr};
  endtask
endmodule

/* testbench/csarp_status_ram_test.sv */
// Self-checking bench for the status register and data memory block.
module csarp_status_ram_test
  import csarp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock, reset_n, watchdog_kick_instruction, halt_instruction, watchdog_timeout;
  logic exec_valid, exec_to_file, exec_indirect, read_en, read_indirect;
  csarp_op_type exec_op;
  logic [7:0] exec_operand_a, exec_operand_b, exec_result, read_data, processor_status;
  logic [15:0] exec_addr, read_addr;
  logic [4:0] bank_select_register;
  logic [7:0] exp_st, exp_res, rnd;
  int fails, total_checks;
  csarp_op_type ops [10];

  csarp_status_ram csarp_status_ram_inst (.clock, .reset_n, .watchdog_kick_instruction,
    .halt_instruction, .watchdog_timeout, .exec_valid, .exec_op, .exec_operand_a,
    .exec_operand_b, .exec_to_file, .exec_indirect, .exec_addr, .exec_result, .read_en,
    .read_indirect, .read_addr, .read_data, .processor_status, .bank_select_register);
  csarp_core_model csarp_core_model_inst (.clock, .watchdog_kick_instruction,
    .halt_instruction, .watchdog_timeout, .exec_valid, .exec_op, .exec_operand_a,
    .exec_operand_b, .exec_to_file, .exec_indirect, .exec_addr, .read_en, .read_indirect,
    .read_addr);

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  ////////////////////////////////////////
  // Reference functions.
  function automatic logic [7:0] lfsr(logic [7:0] v);
    return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction

  function automatic logic [7:0] ref_res(csarp_op_type op, logic [7:0] a, logic [7:0] b,
    logic c);
    case (op)
      CSARP_OP_ADD: return a + b;
      CSARP_OP_SUB: return b + ~a + 8'h01;
      CSARP_OP_AND: return a & b;
      CSARP_OP_OR: return a | b;
      CSARP_OP_XOR: return a ^ b;
      CSARP_OP_ROTR: return {c, b[7:1]};
      CSARP_OP_ROTL: return {b[6:0], c};
      CSARP_OP_CLEAR: return 8'h00;
      CSARP_OP_SWAP: return {b[3:0], b[7:4]};
      default: return a;
    endcase
  endfunction

  function automatic logic [7:0] ref_st(logic [7:0] st, csarp_op_type op, logic [7:0] a,
    logic [7:0] b);
    logic [8:0] s;
    logic [4:0] n;
    logic [7:0] r;
    r = ref_res(op, a, b, st[0]);
    s = {1'b0, a} + {1'b0, b};
    n = {1'b0, a[3:0]} + {1'b0, b[3:0]};
    if (op == CSARP_OP_SUB) begin
      s = {1'b0, b} + {1'b0, ~a} + 9'h001;
      n = {1'b0, b[3:0]} + {1'b0, ~a[3:0]} + 5'h01;
    end
    if (op inside {CSARP_OP_ADD, CSARP_OP_SUB}) st[1:0] = {n[4], s[8]};
    if (op inside {CSARP_OP_ADD, CSARP_OP_SUB, CSARP_OP_AND, CSARP_OP_OR, CSARP_OP_XOR,
      CSARP_OP_CLEAR}) st[2] = (r == 8'h00);
    if (op == CSARP_OP_ROTR) st[0] = b[0];
    if (op == CSARP_OP_ROTL) st[0] = b[7];
    return st;
  endfunction

  ////////////////////////////////////////
  // Shared tasks.
  task automatic check(logic [7:0] seen, logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic final_report();
    if (fails == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic run(csarp_op_type op, logic [7:0] a, logic [7:0] b, logic tf, logic ind,
    logic [15:0] addr);
    exp_res = ref_res(op, a, b, exp_st[0]);
    exp_st = ref_st(exp_st, op, a, b);
    if (tf && !ind && addr[6:0] == CSARP_OFS_STATUS && op inside {CSARP_OP_MOVE,
      CSARP_OP_SWAP}) exp_st[2:0] = exp_res[2:0];
    csarp_core_model_inst.exec(op, a, b, tf, ind, addr);
  endtask

  task automatic settle();
    csarp_core_model_inst.idle();
    check(exec_result, exp_res);
    check(processor_status, exp_st);
  endtask

  task automatic read_chk(logic ind, logic [15:0] addr, logic [7:0] exp);
    csarp_core_model_inst.rd(ind, addr);
    csarp_core_model_inst.idle();
    check(read_data, exp);
  endtask

  task automatic evt(logic k, logic h, logic t);
    csarp_core_model_inst.pulse(k, h, t);
    exp_st[4] = t ? 1'b0 : ((k | h) ? 1'b1 : exp_st[4]);
    exp_st[3] = k ? 1'b1 : (h ? 1'b0 : exp_st[3]);
    csarp_core_model_inst.idle();
    check(processor_status, exp_st);
  endtask

  task automatic do_reset();
    @(negedge clock);
    reset_n = 1'b0;
    repeat (8) @(negedge clock);
    reset_n = 1'b1;
    {exp_st, exp_res} = 16'h1800;
    check(processor_status, 8'h18);
    check(exec_result, 8'h00);
    check({3'h0, bank_select_register}, 8'h00);
  endtask

  ////////////////////////////////////////
  // Main sequence.
  initial begin
    logic [7:0] a;
    logic [7:0] b;
    {reset_n, fails, total_checks, rnd} = {1'b0, 64'h0, 8'h4C};
    ops = '{CSARP_OP_ADD, CSARP_OP_SUB, CSARP_OP_AND, CSARP_OP_OR, CSARP_OP_XOR,
      CSARP_OP_ROTR, CSARP_OP_ROTL, CSARP_OP_CLEAR, CSARP_OP_SWAP, CSARP_OP_MOVE};
    do_reset();
    for (int e = 0; e < 16; e++) evt(e[0], e[1], e[2]);
    run(CSARP_OP_ADD, 8'h0F, 8'h01, 1'b0, 1'b0, 16'h0000);
    settle();
    run(CSARP_OP_ADD, 8'hFF, 8'h01, 1'b0, 1'b0, 16'h0000);
    run(CSARP_OP_ROTL, 8'h00, 8'h40, 1'b0, 1'b0, 16'h0000);
    settle();
    run(CSARP_OP_SUB, 8'h01, 8'h00, 1'b0, 1'b0, 16'h0000);
    settle();
    run(CSARP_OP_SUB, 8'h05, 8'h05, 1'b0, 1'b0, 16'h0000);
    settle();
    for (int i = 0; i < 300; i++) begin
      a = lfsr(rnd);
      b = lfsr(a);
      rnd = lfsr(b);
      run(ops[rnd % 8'h0A], a, b, 1'b0, 1'b0, 16'h0000);
      settle();
    end
    run(CSARP_OP_MOVE, 8'hFF, 8'h00, 1'b1, 1'b0, 16'h0003);
    settle();
    run(CSARP_OP_AND, 8'h00, 8'hFF, 1'b1, 1'b0, 16'h0003);
    settle();
    run(CSARP_OP_CLEAR, 8'h00, 8'h00, 1'b1, 1'b0, 16'h0003);
    settle();
    run(CSARP_OP_SWAP, 8'h00, 8'h50, 1'b1, 1'b0, 16'h0003);
    settle();
    read_chk(1'b0, 16'h0003, exp_st);
    run(CSARP_OP_MOVE, 8'h05, 8'h00, 1'b1, 1'b0, 16'h0008);
    settle();
    check({3'h0, bank_select_register}, 8'h05);
    run(CSARP_OP_MOVE, 8'hA5, 8'h00, 1'b1, 1'b0, 16'h0020);
    run(CSARP_OP_MOVE, 8'h5A, 8'h00, 1'b1, 1'b0, 16'h007F);
    run(CSARP_OP_MOVE, 8'h77, 8'h00, 1'b1, 1'b0, 16'h000C);
    run(CSARP_OP_MOVE, 8'h3C, 8'h00, 1'b1, 1'b1, 16'h204F);
    settle();
    read_chk(1'b1, 16'h2190, 8'hA5);
    read_chk(1'b1, 16'h02A0, 8'hA5);
    read_chk(1'b0, 16'h000C, 8'h00);
    run(CSARP_OP_MOVE, 8'h00, 8'h00, 1'b1, 1'b0, 16'h0008);
    settle();
    read_chk(1'b0, 16'h006F, 8'h3C);
    read_chk(1'b0, 16'h007F, 8'h5A);
    read_chk(1'b1, 16'h1000, 8'h00);
    read_chk(1'b1, 16'h2A00, 8'h00);
    do_reset();
    final_report();
  end

  initial begin
    #(20000 * 4);
    fails++;
    final_report();
  end
endmodule
